// ===== hdl/memory_map_decoder.sv
// address-map decoder with mapping registers that are write-once in normal modes except the EEPROM enable and wait-shutdown bits, and stretch control
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "memory_map_params.svh"
module memory_map_decoder #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  // operating mode and status
  input  wire logic              MODE_SPECIAL,
  input  wire logic              MODE_EXPANDED,
  input  wire logic              MODE_WIDE,
  input  wire logic              WAIT_MODE,
  input  wire logic              DEBUG_MODE,
  input  wire logic              E_STRETCH_ENABLE,
  // register port
  input  wire logic [8:0]        REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [7:0]        REG_RDATA,
  // cpu access
  input  wire logic              ACC_VALID,
  input  wire logic [ADDR_W-1:0] ACC_ADDR,
  input  wire logic              ACC_WRITE,
  input  wire logic              ACC_WIDE,
  // decode results
  output logic      [2:0]        RESOURCE,
  output logic                   FOLLOW_SPACE,
  output logic                   NARROW_BUS,
  output logic                   LOW_BYTE_STROBE,
  output logic                   ADDR0,
  output logic                   READ_WRITE,
  output logic                   BUSY,
  output logic                   E_CLOCK
);

  initial
  begin
    if (ADDR_W != 16)
      $error("address width must be 16");
  end

  // mapping registers
  logic [7:0]  ram_base_select;
  logic [7:0]  register_block_base_select;
  logic [7:0]  eeprom_base_select;
  logic [7:0]  misc_mapping_control;
  logic [3:0]  written;
  logic [7:0]  rdata;
  logic [7:0]  next_ram_base;
  logic [7:0]  next_reg_base;
  logic [7:0]  next_nvm_base;
  logic [7:0]  next_misc;
  logic [3:0]  next_written;
  logic [7:0]  next_rdata;

  // access pipeline
  memory_map_pkg::bus_state_t state;
  memory_map_pkg::bus_state_t next_state;
  logic [1:0]  count;
  logic [1:0]  next_count;
  logic [2:0]  resource;
  logic [2:0]  next_resource;
  logic        follow;
  logic        next_follow;
  logic        narrow;
  logic        next_narrow;
  logic        strobe;
  logic        next_strobe;
  logic        a0;
  logic        next_a0;
  logic        rw;
  logic        next_rw;
  logic        e_clk;
  logic        next_e_clk;

  // decode helpers
  logic        single_chip;
  logic        map_wait_shutdown;
  logic        nvm_enable;
  logic        flash_swap;
  logic        small_flash_enable;
  logic        large_flash_enable;
  logic        hit_regs;
  logic        hit_follow;
  logic        hit_ram;
  logic        hit_nvm;
  logic        hit_small;
  logic        hit_large;
  logic        hit_debug;
  memory_map_pkg::resource_t pick;
  logic [1:0]  stretch;

  // offset to register index; bit 2 flags a mapped offset
  function automatic logic [2:0] reg_index(input logic [8:0] ofs);
    if (ofs == `OFS_RAM_BASE)
      reg_index = 3'h4;
    else if (ofs == `OFS_REG_BASE)
      reg_index = 3'h5;
    else if (ofs == `OFS_NVM_BASE)
      reg_index = 3'h6;
    else if (ofs == `OFS_MISC)
      reg_index = 3'h7;
    else
      reg_index = 3'h0;
  endfunction : reg_index

  assign single_chip        = ~MODE_EXPANDED;
  assign map_wait_shutdown  = register_block_base_select[`WAIT_SHUT_BIT];
  assign nvm_enable         = eeprom_base_select[`NVM_EN_BIT] | single_chip;
  assign flash_swap         = misc_mapping_control[`SWAP_BIT];
  assign small_flash_enable = misc_mapping_control[`SMALL_EN_BIT];
  assign large_flash_enable = misc_mapping_control[`LARGE_EN_BIT];

  // register file
  always_comb
  begin
    logic [2:0] widx;
    logic [2:0] ridx;
    logic       open_w;
    widx          = reg_index(REG_ADDR);
    ridx          = reg_index(REG_ADDR);
    open_w        = 1'b0;
    next_ram_base = ram_base_select;
    next_reg_base = register_block_base_select;
    next_nvm_base = eeprom_base_select;
    next_misc     = misc_mapping_control;
    next_written  = written;
    next_rdata    = 8'h00;
    if (REG_WR && widx[2])
    begin
      open_w = MODE_SPECIAL | ~written[widx[1:0]];
      if (!MODE_SPECIAL)
        next_written[widx[1:0]] = 1'b1;
      case (widx[1:0])
        2'd0:
        begin
          if (open_w)
            next_ram_base[`BASE5_MSB:`BASE5_LSB] = REG_WDATA[`BASE5_MSB:`BASE5_LSB];
        end
        2'd1:
        begin
          if (open_w)
            next_reg_base[`BASE5_MSB:`BASE5_LSB] = REG_WDATA[`BASE5_MSB:`BASE5_LSB];
          if (!MODE_SPECIAL)
            next_reg_base[`WAIT_SHUT_BIT] = REG_WDATA[`WAIT_SHUT_BIT];
        end
        2'd2:
        begin
          if (open_w)
            next_nvm_base[`BASE4_MSB:`BASE4_LSB] = REG_WDATA[`BASE4_MSB:`BASE4_LSB];
          next_nvm_base[`NVM_EN_BIT] = REG_WDATA[`NVM_EN_BIT];
        end
        default:
        begin
          if (open_w)
            next_misc = REG_WDATA;
        end
      endcase
    end
    if (REG_RD && ridx[2])
    begin
      case (ridx[1:0])
        2'd0:    next_rdata = ram_base_select;
        2'd1:    next_rdata = register_block_base_select;
        2'd2:    next_rdata = {eeprom_base_select[7:1], nvm_enable};
        default: next_rdata = misc_mapping_control;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ram_base_select            <= `RST_RAM_BASE;
      register_block_base_select <= `RST_REG_BASE;
      eeprom_base_select         <= `RST_NVM_BASE;
      misc_mapping_control       <= MODE_EXPANDED ? `RST_MISC_EXP : `RST_MISC_SC;
      written                    <= 4'h0;
      rdata                      <= 8'h00;
    end
    else
    begin
      ram_base_select            <= next_ram_base;
      register_block_base_select <= next_reg_base;
      eeprom_base_select         <= next_nvm_base;
      misc_mapping_control       <= next_misc;
      written                    <= next_written;
      rdata                      <= next_rdata;
    end
  end

  // resource compares, all in the same cycle
  always_comb
  begin
    hit_debug  = DEBUG_MODE && ACC_ADDR[15:8] == `DEBUG_ROM_TOP;
    hit_regs   = ACC_ADDR[15:11] == register_block_base_select[`BASE5_MSB:`BASE5_LSB]
                 && ACC_ADDR[10:9] == 2'b00;
    hit_follow = ACC_ADDR[15:11] == register_block_base_select[`BASE5_MSB:`BASE5_LSB]
                 && ACC_ADDR[10:9] == 2'b01;
    hit_ram    = ACC_ADDR[15:11] == ram_base_select[`BASE5_MSB:`BASE5_LSB];
    hit_nvm    = nvm_enable && ACC_ADDR[15:12] == eeprom_base_select[`BASE4_MSB:`BASE4_LSB]
                 && ACC_ADDR[11:10] == 2'b11;
    if (!flash_swap)
    begin
      hit_small = small_flash_enable && !ACC_ADDR[15] && ACC_ADDR[14:12] != 3'h0;
      hit_large = large_flash_enable && ACC_ADDR[15];
    end
    else
    begin
      hit_small = small_flash_enable && ACC_ADDR[15] && ACC_ADDR[14:12] != 3'h0;
      hit_large = large_flash_enable && !ACC_ADDR[15];
    end
    // registers before RAM hides its low 512 bytes
    if (hit_debug)
      pick = memory_map_pkg::RES_DEBUG;
    else if (hit_regs)
      pick = memory_map_pkg::RES_REGS;
    else if (hit_ram)
      pick = memory_map_pkg::RES_RAM;
    else if (hit_nvm)
      pick = memory_map_pkg::RES_NVM;
    else if (hit_small)
      pick = memory_map_pkg::RES_SMALL;
    else if (hit_large)
      pick = memory_map_pkg::RES_LARGE;
    else if (MODE_EXPANDED)
      pick = memory_map_pkg::RES_EXT;
    else
      pick = memory_map_pkg::RES_NONE;
    if (pick == memory_map_pkg::RES_EXT && hit_follow)
      stretch = misc_mapping_control[`FSTR_MSB:`FSTR_LSB];
    else if (pick == memory_map_pkg::RES_EXT)
      stretch = misc_mapping_control[`XSTR_MSB:`XSTR_LSB];
    else
      stretch = 2'b00;
  end

  // access sequencing and bus signals
  always_comb
  begin
    logic take;
    take          = ACC_VALID && state == memory_map_pkg::ST_IDLE
                    && !(map_wait_shutdown && WAIT_MODE);
    next_state    = state;
    next_count    = count;
    next_resource = resource;
    next_follow   = follow;
    next_narrow   = narrow;
    next_strobe   = strobe;
    next_a0       = a0;
    next_rw       = rw;
    next_e_clk    = ~e_clk;
    case (state)
      memory_map_pkg::ST_IDLE:
      begin
        if (take)
        begin
          next_resource = pick;
          next_follow   = pick == memory_map_pkg::RES_EXT && hit_follow;
          next_narrow   = pick == memory_map_pkg::RES_EXT && hit_follow
                          && MODE_WIDE && misc_mapping_control[`NARROW_BIT];
          next_rw       = ~ACC_WRITE;
          if (!ACC_WIDE)
          begin
            next_strobe = ~ACC_ADDR[0];
            next_a0     = ACC_ADDR[0];
          end
          else if (pick == memory_map_pkg::RES_RAM)
          begin
            next_strobe = ACC_ADDR[0];
            next_a0     = ACC_ADDR[0];
          end
          else
          begin
            next_strobe = 1'b0;
            next_a0     = 1'b0;
          end
          if (stretch != 2'b00)
          begin
            next_state = memory_map_pkg::ST_STRETCH;
            next_count = stretch;
            // raise E with the first stretched cycle, not one late
            if (E_STRETCH_ENABLE)
              next_e_clk = 1'b1;
          end
        end
        else
        begin
          next_resource = memory_map_pkg::RES_NONE;
          next_follow   = 1'b0;
          next_narrow   = 1'b0;
        end
      end
      memory_map_pkg::ST_STRETCH:
      begin
        // a free-running E would hand the external part a short cycle
        if (E_STRETCH_ENABLE && count != 2'd1)
          next_e_clk = 1'b1;
        next_count = count - 2'd1;
        if (count == 2'd1)
          next_state = memory_map_pkg::ST_IDLE;
      end
      default:
        next_state = memory_map_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state    <= memory_map_pkg::ST_IDLE;
      count    <= 2'b00;
      resource <= memory_map_pkg::RES_NONE;
      follow   <= 1'b0;
      narrow   <= 1'b0;
      strobe   <= 1'b0;
      a0       <= 1'b0;
      rw       <= 1'b1;
      e_clk    <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      count    <= next_count;
      resource <= next_resource;
      follow   <= next_follow;
      narrow   <= next_narrow;
      strobe   <= next_strobe;
      a0       <= next_a0;
      rw       <= next_rw;
      e_clk    <= next_e_clk;
    end
  end

  // all outputs straight from flip-flops
  assign REG_RDATA       = rdata;
  assign RESOURCE        = resource;
  assign FOLLOW_SPACE    = follow;
  assign NARROW_BUS      = narrow;
  assign LOW_BYTE_STROBE = strobe;
  assign ADDR0           = a0;
  assign READ_WRITE      = rw;
  assign BUSY            = state;
  assign E_CLOCK         = e_clk;

endmodule : memory_map_decoder

// ===== hdl/memory_map_params.svh
// offsets, field positions, reset values and the debug ROM page for the map decoder
// Notes on behaviour
// - overlaps resolve by priority: debug ROM, registers, RAM, EEPROM, flash, external.
// - 512-byte register block starts at 0, movable to any 2K boundary.
// - mapping registers take one write in normal modes, many in special; the EEPROM enable bit and normal-mode wait-shutdown bit take every write.
// - wait-shutdown bit stops decoding in wait; writable only in normal modes.
// - 2K RAM starts at 0, movable to any 2K boundary.
// - at reset the register block hides the lowest 512 RAM bytes.
// - 1K EEPROM starts at 0C00, movable to any 4K boundary.
// - EEPROM enable maps it; reads as 1 in single-chip modes.
// - swap 0: small flash 1000-7FFF, large flash 8000-FFFF.
// - swap 1: small flash 9000-FFFF, large flash 0000-7FFF.
// - flash enables map their arrays; reset 1 single-chip, 0 expanded.
// - narrow bit makes follow space 8-bit only in expanded wide modes.
// - follow space sits 0200-03FF after the register block and moves with it.
// - follow-space stretch of 0 to 3 E clocks, expanded modes only.
// - external stretch of 0 to 3 E clocks, expanded modes only.
// - 8-bit access: strobe 1 with A0 0 even, strobe 0 with A0 1 odd.
// - 16-bit access: strobe 0 and A0 0 aligned; both 1 swapped halves in RAM, both 0 outside RAM.
// - only RAM may show strobe and A0 both 1, in one cycle.
// - mapping register writes act from the next cycle.
// - with stretch enable, E stays high through stretched external cycles.
`ifndef MEMORY_MAP_PARAMS_SVH
`define MEMORY_MAP_PARAMS_SVH
`define OFS_RAM_BASE    9'h010
`define OFS_REG_BASE    9'h011
`define OFS_NVM_BASE    9'h012
`define OFS_MISC        9'h013
`define BASE5_MSB       7
`define BASE5_LSB       3
`define BASE4_MSB       7
`define BASE4_LSB       4
`define WAIT_SHUT_BIT   0
`define NVM_EN_BIT      0
`define SWAP_BIT        7
`define NARROW_BIT      6
`define FSTR_MSB        5
`define FSTR_LSB        4
`define XSTR_MSB        3
`define XSTR_LSB        2
`define SMALL_EN_BIT    1
`define LARGE_EN_BIT    0
`define RST_RAM_BASE    8'h00
`define RST_REG_BASE    8'h00
`define RST_NVM_BASE    8'h01
`define RST_MISC_EXP    8'h0c
`define RST_MISC_SC     8'h0f
`define DEBUG_ROM_TOP   8'hff
`endif

// ===== hdl/memory_map_pkg.sv
// types shared by the map decoder
package memory_map_pkg;
  typedef enum logic [0:0]
  {
    ST_IDLE    = 1'b0,
    ST_STRETCH = 1'b1
  } bus_state_t;
  typedef enum logic [2:0]
  {
    RES_NONE   = 3'b000,
    RES_DEBUG  = 3'b001,
    RES_REGS   = 3'b010,
    RES_RAM    = 3'b011,
    RES_NVM    = 3'b100,
    RES_SMALL  = 3'b101,
    RES_LARGE  = 3'b110,
    RES_EXT    = 3'b111
  } resource_t;
endpackage : memory_map_pkg

// ===== verif/cpu_bus_model.sv
// cpu-side model that issues single-cycle accesses to the decoder
`timescale 1ns/1ps
module cpu_bus_model (
  // clock
  input  wire logic        clk,
  // access lines
  output logic             acc_valid,
  output logic      [15:0] acc_addr,
  output logic             acc_write,
  output logic             acc_wide
);
  initial
  begin
    acc_valid = 1'b0;
    acc_addr  = 16'h0000;
    acc_write = 1'b0;
    acc_wide  = 1'b0;
  end
  // lines flip once released so a stale address never passes for a live one
  task automatic issue(input logic [15:0] a, input logic w, input logic wd);
    acc_valid <= 1'b1;
    acc_addr  <= a;
    acc_write <= w;
    acc_wide  <= wd;
    @(posedge clk);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
    acc_write <= ~w;
    acc_wide  <= ~wd;
  endtask : issue
endmodule : cpu_bus_model

// ===== verif/memory_map_decoder_props.sv
// port-level assertions for the map decoder
`timescale 1ns/1ps
module memory_map_decoder_props #(
  parameter int ADDR_W = 16
) (
  // clock, reset, modes
  input wire logic              REF_CLK,
  input wire logic              RST,
  input wire logic              MODE_EXPANDED,
  input wire logic              MODE_WIDE,
  input wire logic              WAIT_MODE,
  input wire logic              DEBUG_MODE,
  input wire logic              E_STRETCH_ENABLE,
  // register port
  input wire logic              REG_RD,
  input wire logic [7:0]        REG_RDATA,
  // access and results
  input wire logic              ACC_VALID,
  input wire logic [ADDR_W-1:0] ACC_ADDR,
  input wire logic              ACC_WRITE,
  input wire logic              ACC_WIDE,
  input wire logic [2:0]        RESOURCE,
  input wire logic              FOLLOW_SPACE,
  input wire logic              NARROW_BUS,
  input wire logic              LOW_BYTE_STROBE,
  input wire logic              ADDR0,
  input wire logic              READ_WRITE,
  input wire logic              BUSY,
  input wire logic              E_CLOCK
);
  logic       taken;
  logic [2:0] busy_run;
  logic [2:0] next_busy_run;
  // shutdown bit is hidden, so only requests outside wait count
  assign taken = ACC_VALID && !BUSY && !WAIT_MODE;
  always_comb
    next_busy_run = BUSY ? busy_run + 3'h1 : 3'h0;
  always_ff @(posedge REF_CLK)
    busy_run <= RST ? 3'h0 : next_busy_run;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  AST_RW_FOLLOWS: assert property (taken |=> READ_WRITE == !$past(ACC_WRITE))
    else $error("read_write wrong");
  AST_BYTE_LANES: assert property (taken && !ACC_WIDE |=> LOW_BYTE_STROBE == !$past(ACC_ADDR[0])
    && ADDR0 == $past(ACC_ADDR[0])) else $error("byte strobe or addr0 wrong");
  AST_WIDE_ALIGNED: assert property (taken && ACC_WIDE && !ACC_ADDR[0] |=> !LOW_BYTE_STROBE && !ADDR0)
    else $error("aligned word lanes wrong");
  AST_SWAP_RAM_ONLY: assert property (taken && ACC_WIDE && ACC_ADDR[0] |=>
    (LOW_BYTE_STROBE && ADDR0) == (RESOURCE == memory_map_pkg::RES_RAM)) else $error("swapped word outside ram");
  AST_DEBUG_FIRST: assert property (taken && DEBUG_MODE && ACC_ADDR[15:8] == 8'hff |=>
    RESOURCE == memory_map_pkg::RES_DEBUG) else $error("debug rom lost priority");
  AST_STRETCH_BOUND: assert property (busy_run <= 3'h3) else $error("stretch too long");
  AST_BUSY_EXTERNAL: assert property (BUSY |-> RESOURCE == memory_map_pkg::RES_EXT)
    else $error("stretch on internal access");
  AST_EXT_EXPANDED: assert property (RESOURCE == memory_map_pkg::RES_EXT |-> MODE_EXPANDED)
    else $error("external access in single chip");
  AST_NARROW_SCOPE: assert property (NARROW_BUS |-> FOLLOW_SPACE && MODE_WIDE && MODE_EXPANDED)
    else $error("narrow bus outside follow space");
  AST_E_HELD: assert property (BUSY && E_STRETCH_ENABLE |-> E_CLOCK) else $error("e clock dropped");
  AST_RDATA_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data without read");
  cover property (BUSY && E_CLOCK);
  cover property (RESOURCE == memory_map_pkg::RES_RAM && LOW_BYTE_STROBE && ADDR0);
  cover property (NARROW_BUS);
endmodule : memory_map_decoder_props
bind memory_map_decoder memory_map_decoder_props #(.ADDR_W(ADDR_W)) u_props (.REF_CLK(REF_CLK), .RST(RST),
  .MODE_EXPANDED(MODE_EXPANDED), .MODE_WIDE(MODE_WIDE), .WAIT_MODE(WAIT_MODE), .DEBUG_MODE(DEBUG_MODE),
  .E_STRETCH_ENABLE(E_STRETCH_ENABLE), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ACC_VALID(ACC_VALID),
  .ACC_ADDR(ACC_ADDR), .ACC_WRITE(ACC_WRITE), .ACC_WIDE(ACC_WIDE), .RESOURCE(RESOURCE),
  .FOLLOW_SPACE(FOLLOW_SPACE), .NARROW_BUS(NARROW_BUS), .LOW_BYTE_STROBE(LOW_BYTE_STROBE), .ADDR0(ADDR0),
  .READ_WRITE(READ_WRITE), .BUSY(BUSY), .E_CLOCK(E_CLOCK));

// ===== verif/memory_map_decoder_tb.sv
// self-checking bench for the map decoder
`timescale 1ns/1ps
`include "memory_map_params.svh"
module memory_map_decoder_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sp = 1'b1;
  logic        ex = 1'b0;
  logic        wt = 1'b0;
  logic        dbg = 1'b0;
  logic [8:0]  ra = 9'h000;
  logic [7:0]  wd = 8'h00;
  logic        rw = 1'b0;
  logic        rr = 1'b0;
  logic [7:0]  rd;
  logic        av, aw, awd, fol, nar, lbs, a0, rnw, busy, eclk, fseen, nseen, e0;
  logic        wide = 1'b1;
  logic        est = 1'b1;
  logic [15:0] aa;
  logic [2:0]  res;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          nb;
  // address, {write, wide, strobe, a0}, resource
  localparam logic [23:0] ROWS [12] = '{24'h0000_2_2, 24'h01ff_9_2, 24'h0400_4_3, 24'h0401_f_3, 24'h07ff_1_3,
    24'h0c00_2_4, 24'h0fff_9_4, 24'h1000_c_5, 24'h7fff_1_5, 24'h8000_4_6, 24'h8001_4_6, 24'hfeff_1_6};
  memory_map_decoder uut (.REF_CLK(clk), .RST(rst), .MODE_SPECIAL(sp), .MODE_EXPANDED(ex), .MODE_WIDE(wide),
    .WAIT_MODE(wt), .DEBUG_MODE(dbg), .E_STRETCH_ENABLE(est), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(rw),
    .REG_RD(rr), .REG_RDATA(rd), .ACC_VALID(av), .ACC_ADDR(aa), .ACC_WRITE(aw), .ACC_WIDE(awd), .RESOURCE(res),
    .FOLLOW_SPACE(fol), .NARROW_BUS(nar), .LOW_BYTE_STROBE(lbs), .ADDR0(a0), .READ_WRITE(rnw), .BUSY(busy),
    .E_CLOCK(eclk));
  cpu_bus_model cpu (.clk(clk), .acc_valid(av), .acc_addr(aa), .acc_write(aw), .acc_wide(awd));
  always #50 clk = ~clk;
  task automatic final_report();
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    rw <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk);
    rw <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk);
    rr <= 1'b1;
    ra <= a;
    @(posedge clk);
    rr <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", rd, exp);
  endtask : rdc
  task automatic acc(input logic [15:0] a, input logic w, input logic x, input logic [2:0] r, input logic s,
                     input logic z);
    @(posedge clk);
    cpu.issue(a, w, x);
    @(negedge clk);
    fseen = fol;
    nseen = nar;
    chk("resource", 8'(res), 8'(r));
    chk("strobe", 8'(lbs), 8'(s));
    chk("addr0", 8'(a0), 8'(z));
    chk("read_write", 8'(rnw), 8'(!w));
    nb = 0;
    e0 = eclk;
    while (busy === 1'b1 && nb < 8)
    begin
      if (est || nb > 0)
        chk("e_clock", 8'(eclk), est ? 8'h01 : 8'(!e0));
      e0 = eclk;
      nb++;
      @(negedge clk);
    end
  endtask : acc
  task automatic ar(input logic [15:0] a, input logic [2:0] r);
    acc(a, 1'b0, 1'b0, r, !a[0], a[0]);
  endtask : ar
  task automatic do_reset(input logic s, input logic e);
    @(posedge clk);
    rst <= 1'b1;
    sp <= s;
    ex <= e;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i])
      acc(ROWS[i][23:8], ROWS[i][7], ROWS[i][6], ROWS[i][2:0], ROWS[i][5], ROWS[i][4]);
    rdc(`OFS_RAM_BASE, 8'h00);
    rdc(`OFS_REG_BASE, 8'h00);
    rdc(`OFS_NVM_BASE, 8'h01);
    rdc(`OFS_MISC, 8'h0f);
    rdc(9'h014, 8'h00);
    wr(`OFS_NVM_BASE, 8'h00);
    rdc(`OFS_NVM_BASE, 8'h01);
    wr(`OFS_MISC, 8'h8f);
    ar(16'h9000, 3'd5);
    ar(16'h1000, 3'd6);
    wr(`OFS_REG_BASE, 8'h08);
    ar(16'h0000, 3'd3);
    ar(16'h0800, 3'd2);
    wr(`OFS_RAM_BASE, 8'h10);
    ar(16'h1000, 3'd3);
    wr(`OFS_MISC, 8'h8e);
    ar(16'h2000, 3'd0);
    rdc(`OFS_MISC, 8'h8e);
    @(posedge clk);
    dbg <= 1'b1;
    ar(16'hff00, 3'd1);
    do_reset(1'b1, 1'b1);
    dbg <= 1'b0;
    rdc(`OFS_MISC, 8'h0c);
    wr(`OFS_RAM_BASE, 8'h10);
    for (int k = 0; k < 4; k++)
    begin
      wr(`OFS_MISC, 8'h40 | 8'((3 - k) << 4) | 8'(k << 2));
      ar(16'h4000, 3'd7);
      chk("ext_stretch", 8'(nb), 8'(k));
      ar(16'h0200, 3'd7);
      chk("follow_stretch", 8'(nb), 8'(3 - k));
      chk("narrow", 8'(nseen), 8'h01);
    end
    wr(`OFS_REG_BASE, 8'h08);
    ar(16'h0a00, 3'd7);
    chk("follow", 8'(fseen), 8'h01);
    @(posedge clk);
    wide <= 1'b0;
    ar(16'h0a00, 3'd7);
    chk("narrow_off", 8'(nseen), 8'h00);
    do_reset(1'b0, 1'b1);
    wr(`OFS_RAM_BASE, 8'h20);
    wr(`OFS_RAM_BASE, 8'h40);
    rdc(`OFS_RAM_BASE, 8'h20);
    wr(`OFS_REG_BASE, 8'h01);
    @(posedge clk);
    wt <= 1'b1;
    cpu.issue(16'h4000, 1'b1, 1'b0);
    @(negedge clk);
    chk("refused", 8'(res), 8'h00);
    chk("refused_rw", 8'(rnw), 8'h01);
    @(posedge clk);
    wt <= 1'b0;
    ar(16'h4000, 3'd7);
    chk("ext_stretch", 8'(nb), 8'h03);
    @(posedge clk);
    est <= 1'b0;
    ar(16'h4000, 3'd7);
    chk("free_e_stretch", 8'(nb), 8'h03);
    final_report();
  end
endmodule : memory_map_decoder_tb
